// >>> design/timer_pkg.sv
// Package: register offsets, field positions, reset values for the reload/wake-up timers.
// Assumes a classic Wishbone slave with byte-wide registers, one per 32-bit word.
package timer_pkg;
  // Printed offsets are register indices; byte address is index * 4
  localparam logic [7:0] IDX_T3_RELOAD_HIGH = 8'h1F;
  localparam logic [7:0] IDX_T3_RELOAD_LOW  = 8'h20;
  localparam logic [7:0] IDX_T3_COUNT_HIGH  = 8'h21;
  localparam logic [7:0] IDX_T3_COUNT_LOW   = 8'h22;
  localparam logic [7:0] IDX_WK_CONTROL     = 8'h23;
  localparam logic [7:0] IDX_WK_RELOAD_HIGH = 8'h24;
  localparam logic [7:0] IDX_WK_RELOAD_LOW  = 8'h25;
  localparam logic [7:0] IDX_WK_COUNT_HIGH  = 8'h26;
  localparam logic [7:0] IDX_WK_COUNT_LOW   = 8'h27;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h30;
  localparam logic [7:0] IDX_IRQ_CLEAR      = 8'h31;
  localparam logic [7:0] IDX_IRQ_ENABLE     = 8'h32;
  localparam logic [7:0] IDX_T3_START       = 8'h33;
  // Control field positions
  localparam int CTL_RUNNING  = 7;
  localparam int CTL_STROBE   = 6;
  localparam int CTL_TRIM     = 5;
  localparam int CTL_CARD     = 4;
  localparam int CTL_RELOAD   = 3;
  localparam int CTL_WAKE     = 2;
  localparam int CTL_CLK_HI   = 1;
  // Status bit positions
  localparam int ST_WK_UNDER  = 0;
  localparam int ST_T3_UNDER  = 1;
  localparam int ST_CARD      = 2;
  localparam int NUM_EVENTS   = 3;
  // Clock-select divide encodings
  localparam logic [1:0] SEL_DIV1  = 2'h0;
  localparam logic [1:0] SEL_DIV8  = 2'h1;
  localparam logic [1:0] SEL_DIV16 = 2'h2;
  localparam logic [1:0] SEL_DIV32 = 2'h3;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV16_LAST = 5'h0F;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [5:0]  RST_CTL   = 6'h00;
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FIELD = 2'b01,
    SEQ_DONE  = 2'b10
  } card_seq_t;
endpackage

// >>> design/reload_wakeup_timer.sv
// Reload timer (timer 3) registers and counter, full wake-up timer (timer 4) logic.
// Assumes classic Wishbone master on clk; oscillator, tick and detector pins are async.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: Start loads timer 3 from reload bytes
// RL2: Timer 3 live count readable as bytes
// RL3: Software avoids count reads during reception
// RL4: Control bit 7 shows wake-up timer running
// RL5: Run state changes only with strobe bit
// RL6: Auto-trim starts trimming on each underflow
// RL7: Software configures a trimming timer first
// RL8: Auto card-detect runs sequence, card raises interrupt
// RL9: No card gives power-down; restart without gap
// RL10: Timer 3 times the field-on window
// RL11: Auto-reload reloads at zero, else stops
// RL12: Underflow sets the wake-up interrupt flag
// RL13: Auto-wake wakes device on underflow
// RL14: Software sets auto-wake for power-down afterwards
// RL15: Clock select gives divide 1, 8, 16, 32
// RL16: Wake-up timer loads reload at start
// RL17: Running timers decrement per tick; underflow from zero
module reload_wakeup_timer (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        lowFreqOscillator,
  input  wire logic        reloadTimerTick,
  input  wire logic        cardPresent,
  output logic             irq,
  output logic             wakeupTimerIrqFlag,
  output logic             trimStart,
  output logic             cardFieldOn,
  output logic             wakeRequest,
  output logic             powerDownRequest
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncPrev;
  logic       oscSync;
  logic       tickSync;
  logic       cardSync;
  logic       oscEdge;
  logic       t3Edge;
  assign oscSync  = syncB[0];
  assign tickSync = syncB[1];
  assign cardSync = syncB[2];
  assign oscEdge  = oscSync & ~syncPrev[0];
  assign t3Edge   = tickSync & ~syncPrev[1];
  // First stage only feeds the second; logic reads stage two
  always_ff @(posedge clk) begin
    syncA    <= {cardPresent, reloadTimerTick, lowFreqOscillator};
    syncB    <= syncA;
    syncPrev <= syncB;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  t3RelHi, t3RelLo, wkRelHi, wkRelLo;
  logic [15:0] t3Count, wkCount;
  logic        t3Running, wkRunning;
  logic [5:0]  wkCtl;
  logic [4:0]  divCount;
  logic [2:0]  irqStatus, irqEnable;
  timer_pkg::card_seq_t seq;
  logic [7:0]  next_t3RelHi, next_t3RelLo, next_wkRelHi, next_wkRelLo;
  logic [15:0] next_t3Count, next_wkCount;
  logic        next_t3Running, next_wkRunning;
  logic [5:0]  next_wkCtl;
  logic [4:0]  next_divCount;
  logic [2:0]  next_irqStatus, next_irqEnable;
  timer_pkg::card_seq_t next_seq;
  logic [31:0] next_datOut;
  logic        next_ack, next_irq, next_trim, next_field, next_wake, next_pd;

  logic        wrAcc, rdAcc;
  logic [7:0]  idx;
  logic        wkTick, wkUnder, t3Under, t3Start;
  logic [4:0]  divLast;
  logic [2:0]  events;
  // Register index from the word-aligned byte address
  assign idx   = {2'h0, wb_adr_i[7:2]};
  assign wrAcc = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rdAcc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up timer tick divider
  always_comb begin
    case (wkCtl[timer_pkg::CTL_CLK_HI:0])                                    // RL15
      timer_pkg::SEL_DIV1:  divLast = 5'h00;
      timer_pkg::SEL_DIV8:  divLast = timer_pkg::DIV8_LAST;
      timer_pkg::SEL_DIV16: divLast = timer_pkg::DIV16_LAST;
      timer_pkg::SEL_DIV32: divLast = timer_pkg::DIV32_LAST;
      default:              divLast = 5'h00;
    endcase
    wkTick        = 1'b0;
    next_divCount = divCount;
    if (!wkRunning) begin
      next_divCount = 5'h00;
    end else if (oscEdge) begin
      if (divCount >= divLast) begin
        next_divCount = 5'h00;
        wkTick        = 1'b1;                                                // RL15
      end else begin
        next_divCount = divCount + 5'h01;
      end
    end
    // A run-state write restarts the divider so the first period is whole
    if (wrAcc && idx == timer_pkg::IDX_WK_CONTROL && wb_dat_i[timer_pkg::CTL_STROBE]) begin
      next_divCount = 5'h00;                                                 // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers, card detection, registers
  always_comb begin
    next_t3RelHi   = t3RelHi;
    next_t3RelLo   = t3RelLo;
    next_wkRelHi   = wkRelHi;
    next_wkRelLo   = wkRelLo;
    next_t3Count   = t3Count;
    next_wkCount   = wkCount;
    next_t3Running = t3Running;
    next_wkRunning = wkRunning;
    next_wkCtl     = wkCtl;
    next_irqEnable = irqEnable;
    next_seq       = seq;
    next_trim      = 1'b0;
    next_wake      = 1'b0;
    next_pd        = 1'b0;
    events         = 3'h0;
    t3Start        = 1'b0;
    wkUnder        = 1'b0;
    t3Under        = 1'b0;
    // Wake-up timer countdown
    if (wkRunning && wkTick) begin
      if (wkCount == 16'h0000) begin                                         // RL17
        wkUnder = 1'b1;
        // Card detection keeps the period cycling with no gap
        if (wkCtl[timer_pkg::CTL_RELOAD] || wkCtl[timer_pkg::CTL_CARD]) begin  // RL9
          next_wkCount = {wkRelHi, wkRelLo};                                 // RL11
        end else begin
          next_wkRunning = 1'b0;                                             // RL11
        end
      end else begin
        next_wkCount = wkCount - 16'h0001;                                   // RL17
      end
    end
    // Underflow side effects are one-cycle request pulses
    if (wkUnder) begin
      events[timer_pkg::ST_WK_UNDER] = 1'b1;                                 // RL12
      next_trim = wkCtl[timer_pkg::CTL_TRIM];                                // RL6
      next_wake = wkCtl[timer_pkg::CTL_WAKE];                                // RL13
      if (wkCtl[timer_pkg::CTL_CARD]) begin
        next_seq = timer_pkg::SEQ_FIELD;                                     // RL8
        t3Start  = 1'b1;                                                     // RL10
      end
    end
    // Timer 3 first: its underflow closes the window at once
    // Timer 3 is one-shot; its start is decoded further down in this block
    if (t3Running && t3Edge) begin
      if (t3Count == 16'h0000) begin
        t3Under        = 1'b1;                                               // RL17
        next_t3Running = 1'b0;
      end else begin
        next_t3Count = t3Count - 16'h0001;                                   // RL17
      end
    end
    events[timer_pkg::ST_T3_UNDER] = t3Under;
    // Card detection sequence
    // Window ends on a card, or when timer 3 runs out
    case (seq)
      timer_pkg::SEQ_IDLE: ;
      timer_pkg::SEQ_FIELD: begin
        if (cardSync) begin
          events[timer_pkg::ST_CARD] = 1'b1;                                 // RL8
          // One wake pulse per detection, even if auto-wake just asked
          next_wake = ~wakeRequest;                                          // RL8
          next_seq  = timer_pkg::SEQ_DONE;
        end else if (t3Under || !t3Running) begin
          next_pd  = wkCtl[timer_pkg::CTL_WAKE];                             // RL9
          next_seq = timer_pkg::SEQ_DONE;
        end
      end
      timer_pkg::SEQ_DONE: next_seq = timer_pkg::SEQ_IDLE;
      default: next_seq = timer_pkg::SEQ_IDLE;
    endcase
    // Register writes
    // Count bytes are read-only; writes to them fall to default
    if (wrAcc) begin
      case (idx)
        timer_pkg::IDX_T3_RELOAD_HIGH: next_t3RelHi = wb_dat_i[7:0];         // RL1
        timer_pkg::IDX_T3_RELOAD_LOW:  next_t3RelLo = wb_dat_i[7:0];         // RL1
        timer_pkg::IDX_WK_RELOAD_HIGH: next_wkRelHi = wb_dat_i[7:0];         // RL16
        timer_pkg::IDX_WK_RELOAD_LOW:  next_wkRelLo = wb_dat_i[7:0];         // RL16
        timer_pkg::IDX_IRQ_ENABLE:     next_irqEnable = wb_dat_i[2:0];
        timer_pkg::IDX_T3_START:       t3Start = t3Start | wb_dat_i[0];
        timer_pkg::IDX_WK_CONTROL: begin
          next_wkCtl = wb_dat_i[5:0];
          if (wb_dat_i[timer_pkg::CTL_STROBE]) begin                         // RL5
            next_wkRunning = wb_dat_i[timer_pkg::CTL_RUNNING];               // RL5
            if (wb_dat_i[timer_pkg::CTL_RUNNING]) begin
              next_wkCount = {wkRelHi, wkRelLo};                             // RL16
            end
          end
        end
        default: ;
      endcase
    end
    if (t3Start) begin
      next_t3Count   = {t3RelHi, t3RelLo};                                   // RL1
      next_t3Running = 1'b1;
    end
    // Sticky status: set wins over clear
    next_irqStatus = irqStatus;
    if (wrAcc && idx == timer_pkg::IDX_IRQ_CLEAR) begin
      next_irqStatus = irqStatus & ~wb_dat_i[2:0];
    end
    next_irqStatus = next_irqStatus | events;
    next_irq   = |(next_irqStatus & next_irqEnable);
    next_field = (next_seq == timer_pkg::SEQ_FIELD);                         // RL10
    // Read data
    // Clear register reads as zero
    next_datOut = 32'h0000_0000;
    if (rdAcc) begin
      case (idx)
        timer_pkg::IDX_T3_RELOAD_HIGH: next_datOut[7:0] = t3RelHi;
        timer_pkg::IDX_T3_RELOAD_LOW:  next_datOut[7:0] = t3RelLo;
        timer_pkg::IDX_T3_COUNT_HIGH:  next_datOut[7:0] = t3Count[15:8];     // RL2
        timer_pkg::IDX_T3_COUNT_LOW:   next_datOut[7:0] = t3Count[7:0];      // RL2
        timer_pkg::IDX_WK_CONTROL:     next_datOut[7:0] = {wkRunning, 1'b0, wkCtl}; // RL4
        timer_pkg::IDX_WK_RELOAD_HIGH: next_datOut[7:0] = wkRelHi;
        timer_pkg::IDX_WK_RELOAD_LOW:  next_datOut[7:0] = wkRelLo;
        timer_pkg::IDX_WK_COUNT_HIGH:  next_datOut[7:0] = wkCount[15:8];
        timer_pkg::IDX_WK_COUNT_LOW:   next_datOut[7:0] = wkCount[7:0];
        timer_pkg::IDX_IRQ_STATUS:     next_datOut[2:0] = irqStatus;
        timer_pkg::IDX_IRQ_ENABLE:     next_datOut[2:0] = irqEnable;
        default:                       next_datOut = 32'h0000_0000;
      endcase
    end
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage: only stores the next values
  always_ff @(posedge clk) begin
    if (srst) begin
      t3RelHi            <= timer_pkg::RST_BYTE;
      t3RelLo            <= timer_pkg::RST_BYTE;
      wkRelHi            <= timer_pkg::RST_BYTE;
      wkRelLo            <= timer_pkg::RST_BYTE;
      t3Count            <= timer_pkg::RST_WORD;
      wkCount            <= timer_pkg::RST_WORD;
      t3Running          <= 1'b0;
      wkRunning          <= 1'b0;
      wkCtl              <= timer_pkg::RST_CTL;
      divCount           <= 5'h00;
      irqStatus          <= 3'h0;
      irqEnable          <= 3'h0;
      seq                <= timer_pkg::SEQ_IDLE;
      wb_dat_o           <= 32'h0000_0000;
      wb_ack_o           <= 1'b0;
      irq                <= 1'b0;
      wakeupTimerIrqFlag <= 1'b0;
      trimStart          <= 1'b0;
      cardFieldOn        <= 1'b0;
      wakeRequest        <= 1'b0;
      powerDownRequest   <= 1'b0;
    end else begin
      t3RelHi            <= next_t3RelHi;
      t3RelLo            <= next_t3RelLo;
      wkRelHi            <= next_wkRelHi;
      wkRelLo            <= next_wkRelLo;
      t3Count            <= next_t3Count;
      wkCount            <= next_wkCount;
      t3Running          <= next_t3Running;
      wkRunning          <= next_wkRunning;
      wkCtl              <= next_wkCtl;
      divCount           <= next_divCount;
      irqStatus          <= next_irqStatus;
      irqEnable          <= next_irqEnable;
      seq                <= next_seq;
      wb_dat_o           <= next_datOut;
      wb_ack_o           <= next_ack;
      irq                <= next_irq;
      wakeupTimerIrqFlag <= next_irqStatus[timer_pkg::ST_WK_UNDER];          // RL12
      trimStart          <= next_trim;
      cardFieldOn        <= next_field;
      wakeRequest        <= next_wake;
      powerDownRequest   <= next_pd;
    end
  end
endmodule // reload_wakeup_timer
`default_nettype wire

// >>> verif/reload_wakeup_timer_asserts.sv
// Checker: bus handshake and event output assertions for the timer block.
// Assumes it is bound to reload_wakeup_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module reload_wakeup_timer_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wakeupTimerIrqFlag,
  input wire logic trimStart,
  input wire logic cardFieldOn,
  input wire logic wakeRequest,
  input wire logic powerDownRequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_trim_single: assert property (trimStart |=> !trimStart)
    else $error("trim start not a single pulse");
  a_wake_single: assert property (wakeRequest |=> !wakeRequest)
    else $error("wake request not a single pulse");
  a_pd_single: assert property (powerDownRequest |=> !powerDownRequest)
    else $error("power down not a single pulse");
  a_flag_follow: assert property (trimStart |-> ##[0:2] wakeupTimerIrqFlag)
    else $error("underflow did not set flag");
  a_pd_field: assert property (powerDownRequest |-> $past(cardFieldOn))
    else $error("power down without detection window");
endmodule // reload_wakeup_timer_asserts
bind reload_wakeup_timer reload_wakeup_timer_asserts u_chk (
  .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wakeupTimerIrqFlag(wakeupTimerIrqFlag),
  .trimStart(trimStart), .cardFieldOn(cardFieldOn), .wakeRequest(wakeRequest),
  .powerDownRequest(powerDownRequest)
);
`default_nettype wire

// >>> verif/reload_wakeup_timer_tb.sv
// Testbench: drives the bus and async pins of the timer block and checks results.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module reload_wakeup_timer_tb;
  logic        clk = 1'h0;
  logic        srst, cyc, stb, we, osc, tick, card;
  logic [7:0]  adr;
  logic [3:0]  sel, selMask;
  logic [31:0] datI, datO, rdv, seed;
  logic        ack, irq, flag, trim, fieldOn, wake, pd;
  logic [15:0] v, e;
  int          err_count, comparisons, cycles, trimCnt, wakeCnt, pdCnt, d;
  reload_wakeup_timer dut (
    .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .lowFreqOscillator(osc), .reloadTimerTick(tick),
    .cardPresent(card), .irq(irq), .wakeupTimerIrqFlag(flag), .trimStart(trim),
    .cardFieldOn(fieldOn), .wakeRequest(wake), .powerDownRequest(pd)
  );
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ctlExp(input logic run, input logic [5:0] bits);
    return {24'h000000, run, 1'h0, bits};
  endfunction
  task end_sim();
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task acc(input logic w, input logic [7:0] i, input logic [7:0] dt);
    @(posedge clk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; sel <= selMask;
    adr <= {i[5:0], 2'h0}; datI <= {24'h0, dt};
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    rdv = datO;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
  endtask
  task rc(input logic [7:0] i, input logic [31:0] x);
    acc(1'h0, i, 8'h00);
    check(rdv, x);
  endtask
  task pulse(input logic t, input int n);
    repeat (n) begin
      @(posedge clk);
      if (t) tick <= 1'h1;
      else osc <= 1'h1;
      repeat (2) @(posedge clk);
      osc <= 1'h0; tick <= 1'h0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (trim === 1'h1) trimCnt++;
    if (wake === 1'h1) wakeCnt++;
    if (pd === 1'h1) pdCnt++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, osc, tick, card} = 6'h00;
    adr = 8'h00; sel = 4'h0; datI = 32'h0; srst = 1'h1; seed = 32'h00005DF1;
    selMask = 4'hF;
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    for (logic [7:0] i = 8'h1F; i < 8'h28; i++) rc(i, 0);
    rc(8'h3F, 0);
    rdv = xs();
    v = {1'h1, rdv[14:0]};
    acc(1'h1, 8'h1F, v[15:8]);
    acc(1'h1, 8'h20, v[7:0]);
    rc(8'h1F, v[15:8]);
    rc(8'h20, v[7:0]);
    selMask = 4'hE;
    acc(1'h1, 8'h1F, ~v[15:8]);
    selMask = 4'hF;
    rc(8'h1F, v[15:8]);
    acc(1'h1, 8'h21, 8'hFF);
    rc(8'h21, 0);
    acc(1'h1, 8'h33, 8'h01);
    acc(1'h1, 8'h1F, ~v[15:8]);
    pulse(1'h1, 3);
    e = v - 16'h0003;
    rc(8'h21, e[15:8]);
    rc(8'h22, e[7:0]);
    acc(1'h1, 8'h23, 8'h80);
    rc(8'h23, 0);
    for (int s = 0; s < 4; s++) begin
      d = (s == 0) ? 1 : 1 << (s + 2);
      acc(1'h1, 8'h25, 8'h10);
      acc(1'h1, 8'h23, 8'hC0 | s[7:0]);
      acc(1'h1, 8'h25, 8'h55);
      rc(8'h23, 8'h80 | s);
      pulse(1'h0, d - 1);
      rc(8'h27, 8'h10);
      pulse(1'h0, 1);
      rc(8'h27, 8'h0F);
    end
    acc(1'h1, 8'h23, 8'h40);
    rc(8'h23, 0);
    acc(1'h1, 8'h32, 8'h01);
    rc(8'h32, 1);
    acc(1'h1, 8'h25, 8'h02);
    trimCnt = 0;
    wakeCnt = 0;
    acc(1'h1, 8'h23, 8'hEC);
    pulse(1'h0, 3);
    check(trimCnt, 1);
    check(wakeCnt, 1);
    check(flag, 1);
    rc(8'h23, ctlExp(1'h1, 6'h2C));
    rc(8'h27, 8'h02);
    acc(1'h1, 8'h31, 8'h01);
    rc(8'h30, 0);
    check(irq, 0);
    acc(1'h1, 8'h23, 8'hC0);
    pulse(1'h0, 3);
    rc(8'h23, 0);
    rc(8'h30, 1);
    check(irq, 1);
    check(wakeCnt + trimCnt, 2);
    for (int c = 0; c < 2; c++) begin
      acc(1'h1, 8'h31, 8'h07);
      acc(1'h1, 8'h1F, 8'h00);
      acc(1'h1, 8'h20, 8'h01);
      acc(1'h1, 8'h25, 8'h00);
      card <= c[0];
      wakeCnt = 0;
      pdCnt = 0;
      acc(1'h1, 8'h23, 8'hD4);
      pulse(1'h0, 1);
      if (c == 0) check(fieldOn, 1);
      pulse(1'h1, 2);
      acc(1'h0, 8'h30, 8'h00);
      check(rdv & 32'h4, c * 4);
      check(pdCnt, 1 - c);
      check(wakeCnt, 1);
      rc(8'h23, ctlExp(1'h1, 6'h14));
      check(fieldOn, 0);
    end
    end_sim();
  end
endmodule // reload_wakeup_timer_tb
`default_nettype wire
